/* File: verilog/mses_params.svh */
`ifndef MSES_PARAMS_SVH
`define MSES_PARAMS_SVH
// ----------------------------------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------------------------------
`define MSES_IDX_ST0 14'h0402
`define MSES_IDX_ST1 14'h0403
`define MSES_IDX_MASK0 14'h0404
`define MSES_IDX_MASK1 14'h0405
`define MSES_IDX_CFG 14'h0406
`define MSES_IDX_POWER_INTERVAL_COUNT 14'h0407
`define MSES_IDX_ENERGY_INTERVAL_COUNT 14'h0408
`define MSES_IDX_SOFT_RST 14'h0409
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define MSES_ST0_EGY 0
`define MSES_ST0_ACT_LO 1
`define MSES_ST0_REACT_LO 4
`define MSES_ST0_PULSE_LO 7
`define MSES_ST1_FATAL_C 31
`define MSES_ST1_CORR 30
`define MSES_ST1_FATAL_B 29
`define MSES_ST1_FATAL_A 28
`define MSES_ST0_W1C 32'h0000_07ff
`define MSES_ST1_W1C 32'hc000_0000
`define MSES_ST1_FATAL 32'hb000_0000
`define MSES_CFG_MASK 32'h0000_0003
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define MSES_MASK_RST 32'h0000_0000
`define MSES_CFG_RST 2'h0
`define MSES_POWER_INTERVAL_COUNT_RST 24'h0000ff
`define MSES_ENERGY_INTERVAL_COUNT_RST 24'h0000ff
`endif

/* File: verilog/mses_pkg.sv */
package mses_pkg;
    // per-phase sign bits from the power datapath, index 0 is phase a
    typedef struct packed {
        logic [2:0] act_total;
        logic [2:0] act_fund;
        logic [2:0] react_total;
        logic [2:0] react_fund;
    } mses_power_sign_t;

    // fault events: fatal[2] is c, fatal[1] is b, fatal[0] is a
    typedef struct packed {
        logic [2:0] fatal;
        logic corrected;
    } mses_fault_t;

    // energy_power_config fields
    typedef struct packed {
        logic timer_unit;
        logic sign_source;
    } mses_cfg_t;
endpackage : mses_pkg

/* File: verilog/mses_sign_tracker.sv */
`timescale 1ns/1ns
module mses_sign_tracker #(
    parameter int N = 3
) (
    input logic pclk, // bus clock
    input logic presetn, // async reset, active low
    input logic clear, // soft reset pulse
    input logic update, // accumulator refresh strobe
    input logic [N-1:0] sign, // sign bits, one a channel
    output logic [N-1:0] flip // pulse: sign differs from last refresh
);
    logic [N-1:0] prev_ff;
    logic seen_ff;

    // first refresh only arms the tracker, there is nothing to compare
    assign flip = (update && seen_ff) ? (sign ^ prev_ff) : '0;

    // remember the sign seen at each refresh
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_ff <= '0;
            seen_ff <= 1'b0;
        end else if (clear) begin
            prev_ff <= '0;
            seen_ff <= 1'b0;
        end else if (update) begin
            prev_ff <= sign;
            seen_ff <= 1'b1;
        end
    end
endmodule : mses_sign_tracker

/* File: verilog/mses_pulse_polarity.sv */
`timescale 1ns/1ns
module mses_pulse_polarity #(
    parameter int N = 4
) (
    input logic pclk, // bus clock
    input logic presetn, // async reset, active low
    input logic clear, // soft reset pulse
    input logic [N-1:0] pin, // pulse outputs, asynchronous
    input logic [N-1:0] sign, // energy sign of the pulse, 1 negative
    output logic [N-1:0] flip // pulse: polarity differs from last
);
    logic [N-1:0] s1_ff;
    logic [N-1:0] s2_ff;
    logic [N-1:0] s3_ff;
    logic [N-1:0] prev_ff;
    logic [N-1:0] seen_ff;
    logic [N-1:0] fall;

    // high to low on the synchronised pin marks an issued pulse
    assign fall = s3_ff & ~s2_ff;
    assign flip = fall & seen_ff & (sign ^ prev_ff);

    // two flops before any logic reads the pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
        end else begin
            s1_ff <= pin;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // each output keeps the polarity of its own last pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_ff <= '0;
            seen_ff <= '0;
        end else if (clear) begin
            prev_ff <= '0;
            seen_ff <= '0;
        end else begin
            prev_ff <= (prev_ff & ~fall) | (sign & fall);
            seen_ff <= seen_ff | fall;
        end
    end
endmodule : mses_pulse_polarity

/* File: verilog/mses_status.sv */
`timescale 1ns/1ns
`include "mses_params.svh"
module mses_status #(
    parameter int CNT_W = 24
) (
    input logic pclk, // bus clock, 250 mhz
    input logic presetn, // async reset, active low
    input logic [15:0] paddr, // apb byte address
    input logic psel, // apb select
    input logic penable, // apb access phase
    input logic pwrite, // apb direction, 1 write
    input logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error, unmapped address
    input logic [3:0] pulse_out, // pulse_out_1..4 pins
    input logic [3:0] pulse_sign, // sign carried by each pulse
    input logic sample_8k, // one pulse per 8 ksps sample
    input logic line_cycle, // one pulse per line cycle
    input mses_pkg::mses_power_sign_t power_sign, // phase signs
    input mses_pkg::mses_fault_t fault_event, // fault pulses
    output logic irq, // level, unmasked flag set
    output logic nmi, // level, fatal fault flag set
    output logic power_refresh, // pulse, power accumulators refresh
    output logic energy_refresh // pulse, energy accumulators update
);
    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    function automatic logic [15:0] idx2addr(input logic [13:0] idx);
        return {idx, 2'b00};
    endfunction : idx2addr

    // interval ends on the event that meets the programmed count
    function automatic logic at_end(input logic ev,
                                    input logic [CNT_W-1:0] cnt,
                                    input logic [CNT_W-1:0] lim);
        return ev && (cnt == lim);
    endfunction : at_end

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [31:0] st0_ff;
    logic [31:0] st1_ff;
    logic [31:0] mask0_ff;
    logic [31:0] mask1_ff;
    mses_pkg::mses_cfg_t cfg_ff;
    logic [CNT_W-1:0] power_interval_count_ff;
    logic [CNT_W-1:0] energy_interval_count_ff;
    logic [CNT_W-1:0] pwr_cnt_ff;
    logic [CNT_W-1:0] egy_cnt_ff;
    logic pwr_refresh_ff;
    logic egy_refresh_ff;
    logic srst_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic irq_ff;
    logic nmi_ff;
    logic [31:0] nxt_st0;
    logic [31:0] nxt_st1;

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    logic acc;
    logic done;
    logic wr;
    logic hit_st0;
    logic hit_st1;
    logic hit_mask0;
    logic hit_mask1;
    logic hit_cfg;
    logic hit_pwr;
    logic hit_egy;
    logic hit_srst;
    logic mapped;
    logic [31:0] rd_data;

    // answer one cycle into the access phase; the write lands on the
    // edge at which the master sees pready high
    assign acc = psel && penable;
    assign done = acc && pready_ff;
    assign wr = done && pwrite && !pslverr_ff;
    assign hit_st0 = paddr == idx2addr(`MSES_IDX_ST0);
    assign hit_st1 = paddr == idx2addr(`MSES_IDX_ST1);
    assign hit_mask0 = paddr == idx2addr(`MSES_IDX_MASK0);
    assign hit_mask1 = paddr == idx2addr(`MSES_IDX_MASK1);
    assign hit_cfg = paddr == idx2addr(`MSES_IDX_CFG);
    assign hit_pwr = paddr == idx2addr(`MSES_IDX_POWER_INTERVAL_COUNT);
    assign hit_egy = paddr == idx2addr(`MSES_IDX_ENERGY_INTERVAL_COUNT);
    assign hit_srst = paddr == idx2addr(`MSES_IDX_SOFT_RST);
    assign mapped = |{hit_st0, hit_st1, hit_mask0, hit_mask1,
                      hit_cfg, hit_pwr, hit_egy, hit_srst};

    // read mux; soft reset register reads as zero
    assign rd_data = hit_st0 ? st0_ff :
                     hit_st1 ? st1_ff :
                     hit_mask0 ? mask0_ff :
                     hit_mask1 ? mask1_ff :
                     hit_cfg ? {30'h0000_0000, cfg_ff} :
                     hit_pwr ? 32'(power_interval_count_ff) :
                     hit_egy ? 32'(energy_interval_count_ff) : 32'h0000_0000;

    // bus answer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            pready_ff <= acc && !pready_ff;
            pslverr_ff <= acc && !pready_ff && !mapped;
            prdata_ff <= (acc && !pready_ff) ? rd_data : prdata_ff;
        end
    end

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask0_ff <= `MSES_MASK_RST;
            mask1_ff <= `MSES_MASK_RST;
            cfg_ff <= `MSES_CFG_RST;
            power_interval_count_ff <= CNT_W'(`MSES_POWER_INTERVAL_COUNT_RST);
            energy_interval_count_ff <= CNT_W'(`MSES_ENERGY_INTERVAL_COUNT_RST);
        end else if (wr) begin
            if (hit_mask0) mask0_ff <= pwdata & `MSES_ST0_W1C;
            if (hit_mask1) mask1_ff <= pwdata & `MSES_ST1_W1C;
            if (hit_cfg) cfg_ff <= pwdata[1:0];
            if (hit_pwr) power_interval_count_ff <= pwdata[CNT_W-1:0];
            if (hit_egy) energy_interval_count_ff <= pwdata[CNT_W-1:0];
        end
    end

    // soft reset is a one-cycle pulse; it clears every flag including
    // the read-only fatal a and b ones, which only it and presetn can clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) srst_ff <= 1'b0;
        else srst_ff <= wr && hit_srst && pwdata[0];
    end

    // ----------------------------------------------------------------
    // refresh interval counters
    // ----------------------------------------------------------------
    logic egy_ev;
    logic pwr_end;
    logic egy_end;

    // the unit bit picks samples or line cycles for the energy timer
    assign egy_ev = cfg_ff.timer_unit ? line_cycle : sample_8k;
    assign pwr_end = at_end(sample_8k, pwr_cnt_ff, power_interval_count_ff);
    assign egy_end = at_end(egy_ev, egy_cnt_ff, energy_interval_count_ff);

    // a count of n refreshes on event n+1; a new limit below the
    // running count takes effect once the counter wraps or a soft reset clears it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_cnt_ff <= '0;
            egy_cnt_ff <= '0;
            pwr_refresh_ff <= 1'b0;
            egy_refresh_ff <= 1'b0;
        end else if (srst_ff) begin
            pwr_cnt_ff <= '0;
            egy_cnt_ff <= '0;
            pwr_refresh_ff <= 1'b0;
            egy_refresh_ff <= 1'b0;
        end else begin
            if (pwr_end) pwr_cnt_ff <= '0;
            else if (sample_8k) pwr_cnt_ff <= pwr_cnt_ff + 1'b1;
            if (egy_end) egy_cnt_ff <= '0;
            else if (egy_ev) egy_cnt_ff <= egy_cnt_ff + 1'b1;
            pwr_refresh_ff <= pwr_end;
            egy_refresh_ff <= egy_end;
        end
    end

    // ----------------------------------------------------------------
    // sign change detection
    // ----------------------------------------------------------------
    logic [2:0] act_sign;
    logic [2:0] react_sign;
    logic [2:0] act_flip;
    logic [2:0] react_flip;
    logic [3:0] pulse_flip;

    // one select bit steers both active and reactive monitoring
    assign act_sign = cfg_ff.sign_source ? power_sign.act_fund
                                         : power_sign.act_total;
    assign react_sign = cfg_ff.sign_source ? power_sign.react_fund
                                           : power_sign.react_total;

    mses_sign_tracker #(.N(3)) u_act (
        .pclk(pclk),
        .presetn(presetn),
        .clear(srst_ff),
        .update(pwr_refresh_ff),
        .sign(act_sign),
        .flip(act_flip)
    );

    mses_sign_tracker #(.N(3)) u_react (
        .pclk(pclk),
        .presetn(presetn),
        .clear(srst_ff),
        .update(pwr_refresh_ff),
        .sign(react_sign),
        .flip(react_flip)
    );

    mses_pulse_polarity #(.N(4)) u_pulse (
        .pclk(pclk),
        .presetn(presetn),
        .clear(srst_ff),
        .pin(pulse_out),
        .sign(pulse_sign),
        .flip(pulse_flip)
    );

    // ----------------------------------------------------------------
    // status flags
    // ----------------------------------------------------------------
    logic [31:0] set0;
    logic [31:0] set1;
    logic [31:0] clr0;
    logic [31:0] clr1;

    assign set0 = {21'h00_0000, pulse_flip, react_flip, act_flip,
                   egy_refresh_ff};
    assign set1 = {fault_event.fatal[2], fault_event.corrected,
                   fault_event.fatal[1:0], 28'h000_0000};
    // only writable bits clear; zeros and read-only bits are kept
    assign clr0 = (wr && hit_st0) ? (pwdata & `MSES_ST0_W1C) : '0;
    assign clr1 = (wr && hit_st1) ? (pwdata & `MSES_ST1_W1C) : '0;
    // a set in the clearing cycle wins over the clear
    assign nxt_st0 = (st0_ff & ~clr0) | set0;
    assign nxt_st1 = (st1_ff & ~clr1) | set1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st0_ff <= 32'h0000_0000;
            st1_ff <= 32'h0000_0000;
        end else if (srst_ff) begin
            st0_ff <= 32'h0000_0000;
            st1_ff <= 32'h0000_0000;
        end else begin
            st0_ff <= nxt_st0;
            st1_ff <= nxt_st1;
        end
    end

    // interrupt lines; the fatal line ignores the mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_ff <= 1'b0;
            nmi_ff <= 1'b0;
        end else begin
            irq_ff <= |(st0_ff & mask0_ff) || |(st1_ff & mask1_ff);
            nmi_ff <= |(st1_ff & `MSES_ST1_FATAL);
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign irq = irq_ff;
    assign nmi = nmi_ff;
    assign power_refresh = pwr_refresh_ff;
    assign energy_refresh = egy_refresh_ff;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // flag 4 goes from clear to set across one edge
    sequence s_flag4_rise;
        !st0_ff[10] ##1 st0_ff[10];
    endsequence

    a_pulse4_flag: assert property (
        pulse_flip[3] && !srst_ff |=> st0_ff[10])
        else $error("pulse 4 polarity flag not set");
    a_pulse_flags: assert property (
        (pulse_flip[2:0] != 3'h0) && !srst_ff |=>
        ((st0_ff[9:7] & $past(pulse_flip[2:0])) == $past(pulse_flip[2:0])))
        else $error("pulse polarity flag not set");
    a_pulse_edge_only: assert property (
        s_flag4_rise |-> $past(pulse_flip[3]))
        else $error("pulse 4 flag set without a falling edge");
    a_react_flags: assert property (
        (react_flip != 3'h0) && !srst_ff |=>
        ((st0_ff[6:4] & $past(react_flip)) == $past(react_flip)))
        else $error("reactive sign flag not set");
    a_act_flags: assert property (
        (act_flip != 3'h0) && !srst_ff |=>
        ((st0_ff[3:1] & $past(act_flip)) == $past(act_flip)))
        else $error("active sign flag not set");
    a_src_select: assert property (
        cfg_ff.sign_source && pwr_refresh_ff |->
        act_sign == power_sign.act_fund &&
        react_sign == power_sign.react_fund)
        else $error("sign source not fundamental");
    a_flip_at_refresh: assert property (
        (act_flip != 3'h0 || react_flip != 3'h0) |-> pwr_refresh_ff)
        else $error("sign flag outside power refresh");
    a_pwr_interval: assert property (
        pwr_refresh_ff |-> $past(sample_8k) &&
        $past(pwr_cnt_ff) == $past(power_interval_count_ff))
        else $error("power refresh at wrong count");
    a_energy_ready: assert property (
        egy_refresh_ff && !srst_ff |=> st0_ff[0])
        else $error("energy ready flag not set");
    a_fatal_sticky: assert property (
        st1_ff[29] && !srst_ff |=> st1_ff[29])
        else $error("fatal flag b cleared without reset");
    a_nmi_follow: assert property (
        (st1_ff & `MSES_ST1_FATAL) != 32'h0 && !srst_ff |=> nmi_ff)
        else $error("nmi not raised for fatal flag");
    a_corrected: assert property (
        fault_event.corrected && !srst_ff |=> st1_ff[30])
        else $error("corrected fault flag not set");
    a_w1c_clear: assert property (
        wr && hit_st0 && pwdata[0] && !egy_refresh_ff && !srst_ff
        |=> !st0_ff[0])
        else $error("write one did not clear flag");
    a_pready_pulse: assert property (
        pready_ff |=> !pready_ff)
        else $error("pready held more than one cycle");
endmodule : mses_status

/* File: verification/tb_top.sv */
`timescale 1ns/1ns
`include "mses_params.svh"
module tb_top;
    // ------------------------------------------------------------
    // stimulus and dut
    // ------------------------------------------------------------
    typedef struct {
        logic wr;
        logic [31:0] exp;
        logic err;
        string nm;
    } mses_note_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, irq, nmi;
    logic [3:0] pulse_out = 4'h0;
    logic [3:0] pulse_sign = 4'h0;
    logic sample_8k = 1'b0;
    logic line_cycle = 1'b0;
    mses_pkg::mses_power_sign_t ps = '0;
    mses_pkg::mses_fault_t fe = '0;
    mses_note_t notes[$];
    mses_note_t n;
    int failures = 0;
    int checked = 0;
    integer seed = 32'hf08c7cb5;
    logic [3:0] s, r;
    logic [2:0] ta, tr, fv;
    logic pwr_rf;
    logic egy_rf;
    int n_pwr = 0;
    int n_egy = 0;

    always #2 pclk = ~pclk; // 250 mhz

    mses_status dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pulse_out(pulse_out), .pulse_sign(pulse_sign),
        .sample_8k(sample_8k), .line_cycle(line_cycle), .power_sign(ps),
        .fault_event(fe), .irq(irq), .nmi(nmi), .power_refresh(pwr_rf),
        .energy_refresh(egy_rf));

    // count refresh pulses; a stretched pulse would count twice
    always @(posedge pclk) begin
        if (pwr_rf === 1'b1) n_pwr++;
        if (egy_rf === 1'b1) n_egy++;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] ad(input logic [13:0] i);
        return {i, 2'b00};
    endfunction : ad

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic end_of_test;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_of_test

    // one apb transfer; the expected answer is noted for the monitor
    task automatic apb(input logic wr, input logic [15:0] a,
                       input logic [31:0] d, input logic [31:0] e,
                       input logic er, input string nm);
        mses_note_t t;
        t.wr = wr;
        t.exp = e;
        t.err = er;
        t.nm = nm;
        @(posedge pclk);
        notes.push_back(t);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the watchdog ends a wait that never sees pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0, "write");
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [31:0] e,
                      input string nm);
        apb(1'b0, a, 32'h0, e, 1'b0, nm);
    endtask : rd

    // n strobes of the sample tick or the line-cycle tick
    task automatic tick(input bit line, input int cnt);
        repeat (cnt) begin
            @(posedge pclk);
            if (line) line_cycle <= 1'b1;
            else sample_8k <= 1'b1;
            @(posedge pclk);
            line_cycle <= 1'b0;
            sample_8k <= 1'b0;
            repeat (3) @(posedge pclk);
        end
    endtask : tick

    // sign held long past the late sampling point of the falling edge
    task automatic pulses(input logic [3:0] sg);
        @(posedge pclk);
        pulse_sign <= sg;
        pulse_out <= 4'hf;
        repeat (3) @(posedge pclk);
        pulse_out <= 4'h0;
        repeat (8) @(posedge pclk);
    endtask : pulses

    task automatic power_step(input logic [5:0] fl, input string nm);
        tick(1'b0, 2);
        rd(ad(`MSES_IDX_ST0), 32'h0, nm);
        tick(1'b0, 1);
        rd(ad(`MSES_IDX_ST0), {25'h0, fl, 1'b1}, nm);
        wr(ad(`MSES_IDX_ST0), `MSES_ST0_W1C);
    endtask : power_step

    task automatic fault(input mses_pkg::mses_fault_t f);
        @(posedge pclk);
        fe <= f;
        @(posedge pclk);
        fe <= '0;
        repeat (3) @(posedge pclk);
    endtask : fault

    // ------------------------------------------------------------
    // monitor: compares each completed transfer with the oldest note
    // ------------------------------------------------------------
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && notes.size() > 0) begin
            n = notes.pop_front();
            check({n.nm, " err"}, {31'h0, pslverr}, {31'h0, n.err});
            if (!n.wr)
                check(n.nm, prdata, n.exp);
        end
    end

    // watchdog, well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge pclk);
        failures++;
        end_of_test();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd(ad(`MSES_IDX_ST0), 32'h0, "st0 rst");
        rd(ad(`MSES_IDX_ST1), 32'h0, "st1 rst");
        rd(ad(`MSES_IDX_MASK0), 32'h0, "mask0 rst");
        rd(ad(`MSES_IDX_CFG), 32'h0, "cfg rst");
        rd(ad(`MSES_IDX_POWER_INTERVAL_COUNT), 32'hff, "pwr rst");
        apb(1'b0, 16'h0ffc, 32'h0, 32'h0, 1'b1, "unmapped");
        $display("test reset done");
        // first pulse only arms, a repeat of the same sign flags nothing
        s = 4'($random(seed));
        pulses(s);
        pulses(s);
        rd(ad(`MSES_IDX_ST0), 32'h0, "pulse same");
        for (int k = 0; k < 2; k++) begin
            r = k ? ~r : 4'($random(seed));
            s = s ^ r;
            pulses(s);
            rd(ad(`MSES_IDX_ST0), {21'h0, r, 7'h0}, "pulse");
            wr(ad(`MSES_IDX_ST0), 32'h0);
            rd(ad(`MSES_IDX_ST0), {21'h0, r, 7'h0}, "w0 keep");
            wr(ad(`MSES_IDX_ST0), `MSES_ST0_W1C);
            rd(ad(`MSES_IDX_ST0), 32'h0, "w1 clr");
        end
        $display("test pulse done");
        // power signs: fund kept equal to total before the source swap
        wr(ad(`MSES_IDX_POWER_INTERVAL_COUNT), 32'h2);
        wr(ad(`MSES_IDX_ENERGY_INTERVAL_COUNT), 32'h2);
        s = 4'($random(seed));
        ps <= {s[2:0], s[2:0], s[2:0], s[2:0]};
        power_step(6'h0, "arm");
        ta = 3'($random(seed));
        tr = 3'($random(seed));
        ps.act_total <= ps.act_total ^ ta;
        ps.react_total <= ps.react_total ^ tr;
        power_step({tr, ta}, "total");
        ps.act_fund <= ps.act_total;
        ps.react_fund <= ps.react_total;
        power_step(6'h0, "fund ignored");
        wr(ad(`MSES_IDX_CFG), 32'h1);
        ta = 3'($random(seed));
        tr = 3'($random(seed));
        ps.act_fund <= ps.act_fund ^ ta;
        ps.react_fund <= ps.react_fund ^ tr;
        ps.act_total <= ps.act_total ^ 3'($random(seed));
        power_step({tr, ta}, "fund");
        // energy timer counted in line cycles
        wr(ad(`MSES_IDX_CFG), 32'h3);
        tick(1'b0, 3);
        tick(1'b1, 2);
        rd(ad(`MSES_IDX_ST0), 32'h0, "egy line");
        tick(1'b1, 1);
        rd(ad(`MSES_IDX_ST0), 32'h1, "egy line");
        check("pwr refreshes", n_pwr, 32'h5);
        check("egy refreshes", n_egy, 32'h5);
        $display("test power done");
        // corrected fault reaches irq only through its mask bit
        fault(4'b0001);
        rd(ad(`MSES_IDX_ST1), 32'h4000_0000, "corr");
        @(negedge pclk);
        check("nmi corr", {31'h0, nmi}, 32'h0);
        check("irq masked", {31'h0, irq}, 32'h0);
        wr(ad(`MSES_IDX_MASK1), 32'h4000_0000);
        repeat (2) @(negedge pclk);
        check("irq", {31'h0, irq}, 32'h1);
        wr(ad(`MSES_IDX_ST1), 32'h4000_0000);
        repeat (2) @(negedge pclk);
        check("irq clr", {31'h0, irq}, 32'h0);
        fv = 3'($random(seed)) | 3'b010;
        fault({fv, 1'b0});
        @(negedge pclk);
        check("nmi", {31'h0, nmi}, 32'h1);
        rd(ad(`MSES_IDX_ST1), {fv[2], 1'b0, fv[1:0], 28'h0}, "fatal");
        wr(ad(`MSES_IDX_ST1), 32'hffff_ffff);
        rd(ad(`MSES_IDX_ST1), {2'b00, fv[1:0], 28'h0}, "fatal ro");
        @(negedge pclk);
        check("nmi held", {31'h0, nmi}, 32'h1);
        wr(ad(`MSES_IDX_SOFT_RST), 32'h1);
        rd(ad(`MSES_IDX_ST1), 32'h0, "soft rst");
        @(negedge pclk);
        check("nmi soft", {31'h0, nmi}, 32'h0);
        rd(ad(`MSES_IDX_MASK1), 32'h4000_0000, "mask kept");
        // hardware reset in mid-run clears fatal flags and masks alike
        fault({fv, 1'b0});
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(ad(`MSES_IDX_ST1), 32'h0, "hw rst");
        rd(ad(`MSES_IDX_MASK1), 32'h0, "mask1 rst");
        @(negedge pclk);
        check("nmi hw rst", {31'h0, nmi}, 32'h0);
        $display("test fault done");
        end_of_test();
    end
endmodule : tb_top
